// ===== adfsr_defines.svh
// register offsets, field positions, reset values for the status bank
`ifndef ADFSR_DEFINES_SVH
`define ADFSR_DEFINES_SVH
`define ADFSR_ADDR_DIAG_CH12   8'h0C
`define ADFSR_ADDR_DIAG_CH34   8'h0D
`define ADFSR_ADDR_LINE_OUT    8'h0E
`define ADFSR_ADDR_CH_STATE    8'h0F
`define ADFSR_ADDR_CH_FAULT    8'h10
`define ADFSR_ADDR_GLOBAL_ONE  8'h11
`define ADFSR_RST_DIAG         8'h00
`define ADFSR_RST_LINE_OUT     4'h0
`define ADFSR_RST_CH_STATE     8'h55
`define ADFSR_RST_FAULT        8'h00
`define ADFSR_RST_GLOBAL       5'h00
`define ADFSR_BIT_S2G          3
`define ADFSR_BIT_S2P          2
`define ADFSR_BIT_OPEN         1
`define ADFSR_BIT_SHORTED      0
`define ADFSR_BIT_CLK_BAD      4
`define ADFSR_BIT_OUT_OV       3
`define ADFSR_BIT_BAT_OV       2
`define ADFSR_BIT_OUT_UV       1
`define ADFSR_BIT_BAT_UV       0
`endif

// ===== adfsr_pkg.sv
// types shared by the amplifier status register bank
package adfsr_pkg;
  typedef enum logic [1:0] {
    ADFSR_PLAY   = 2'h0,
    ADFSR_HIZ    = 2'h1,
    ADFSR_MUTE   = 2'h2,
    ADFSR_DCDIAG = 2'h3
  } adfsr_ch_state_e;
endpackage : adfsr_pkg

// ===== adfsr_status_regs.sv
// read-only diagnostic and fault status register bank, four channels
`timescale 1ns/1ps
`default_nettype none
`include "adfsr_defines.svh"
module adfsr_status_regs (
  // clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // register port from the serial control bus
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  // diagnostic control from the control registers
  input  wire logic       auto_diag_skip,
  input  wire logic       line_level_diag_enable,
  // diagnostic engine results, one nibble per channel, ch1 in [15:12]
  input  wire logic       diag_done,
  input  wire logic [15:0] diag_result,
  input  wire logic [3:0] line_level_detect_flag,
  // channel state and fault sources, ch1 in the top bits
  input  wire logic [7:0] ch_state,
  input  wire logic [3:0] overcurrent_flag,
  input  wire logic [3:0] dc_offset_fault_flag,
  // global fault sources
  input  wire logic       clock_invalid,
  input  wire logic       output_supply_overvoltage,
  input  wire logic       battery_overvoltage,
  input  wire logic       output_supply_undervoltage,
  input  wire logic       battery_undervoltage,
  // request to run diagnostics
  output logic            diag_start
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers: sources come from analog monitors
  localparam int NSYNC = 38;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;

  // one channel field decoded to "sits in high impedance"
  function automatic logic hiz_of(input logic [1:0] st);
    hiz_of = (st == 2'(adfsr_pkg::ADFSR_HIZ));
  endfunction : hiz_of

  assign raw_in = {diag_done, diag_result, line_level_detect_flag,
                   overcurrent_flag, dc_offset_fault_flag, clock_invalid,
                   output_supply_overvoltage, battery_overvoltage,
                   output_supply_undervoltage, battery_undervoltage,
                   hiz_of(ch_state[7:6]), hiz_of(ch_state[5:4]),
                   hiz_of(ch_state[3:2]), hiz_of(ch_state[1:0])};

  // high-z bits reset to 1 so that reset itself never looks like an exit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {{(NSYNC-4){1'b0}}, 4'hF};
      sync_q <= {{(NSYNC-4){1'b0}}, 4'hF};
    end else if (clk_en) begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  logic [7:0] state_meta_q;
  logic [7:0] state_sync_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_meta_q <= `ADFSR_RST_CH_STATE;
      state_sync_q <= `ADFSR_RST_CH_STATE;
    end else if (clk_en) begin
      state_meta_q <= ch_state;
      state_sync_q <= state_meta_q;
    end
  end

  logic        s_done;
  logic [15:0] s_result;
  logic [3:0]  s_line;
  logic [3:0]  s_oc;
  logic [3:0]  s_dc;
  logic [4:0]  s_global;
  logic [3:0]  s_hiz;
  assign s_done   = sync_q[37];
  assign s_result = sync_q[36:21];
  assign s_line   = sync_q[20:17];
  assign s_oc     = sync_q[16:13];
  assign s_dc     = sync_q[12:9];
  assign s_global = sync_q[8:4];
  assign s_hiz    = sync_q[3:0];

  ////////////////////////////////////////////////////////////////////////
  // automatic diagnostic trigger
  logic [3:0] hiz_prev_q;
  logic       fault_prev_q;
  logic       fault_any;
  logic       leave_hiz;
  logic       fault_rise;
  assign fault_any  = |{s_oc, s_dc};
  assign leave_hiz  = |(hiz_prev_q & ~s_hiz);
  assign fault_rise = fault_any & ~fault_prev_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hiz_prev_q   <= 4'hF;
      fault_prev_q <= 1'b0;
      diag_start   <= 1'b0;
    end else if (clk_en) begin
      hiz_prev_q   <= s_hiz;
      fault_prev_q <= fault_any;
      diag_start   <= !auto_diag_skip && (leave_hiz || fault_rise);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status registers; no write path exists, so writes never alter them
  // reg_wr and reg_wdata reach no register on purpose
  logic [7:0] diag_ch12_q;
  logic [7:0] diag_ch34_q;
  logic [3:0] line_out_q;
  logic [7:0] ch_fault_q;
  logic [4:0] global_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_ch12_q <= `ADFSR_RST_DIAG;
      diag_ch34_q <= `ADFSR_RST_DIAG;
    end else if (clk_en && s_done) begin
      diag_ch12_q <= s_result[15:8];
      diag_ch34_q <= s_result[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_out_q <= `ADFSR_RST_LINE_OUT;
    end else if (clk_en && s_done && line_level_diag_enable) begin
      line_out_q <= s_line;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ch_fault_q <= `ADFSR_RST_FAULT;
      global_q   <= `ADFSR_RST_GLOBAL;
    end else if (clk_en) begin
      ch_fault_q <= {s_oc, s_dc};
      global_q   <= s_global;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read decode
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a >= `ADFSR_ADDR_DIAG_CH12) &&
                (a <= `ADFSR_ADDR_GLOBAL_ONE);
  endfunction : is_mapped

  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `ADFSR_ADDR_DIAG_CH12:  rd_mux = diag_ch12_q;
      `ADFSR_ADDR_DIAG_CH34:  rd_mux = diag_ch34_q;
      `ADFSR_ADDR_LINE_OUT:   rd_mux = {4'h0, line_out_q};
      `ADFSR_ADDR_CH_STATE:   rd_mux = state_sync_q;
      `ADFSR_ADDR_CH_FAULT:   rd_mux = ch_fault_q;
      `ADFSR_ADDR_GLOBAL_ONE: rd_mux = {3'h0, global_q};
      default:                rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  assign reg_hit = (reg_rd || reg_wr) && is_mapped(reg_addr);

  ////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_leave_hiz;
    clk_en && !auto_diag_skip && leave_hiz;
  endsequence

  a_diag_on_leave: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_leave_hiz |=> diag_start)
    else $error("diag not started on leaving high-z");
  a_diag_skip_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && auto_diag_skip |=> !diag_start)
    else $error("diag started while skipped");
  a_line_hold_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !line_level_diag_enable |=> $stable(line_out_q))
    else $error("line result changed while disabled");
  a_diag_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && s_done |=> {diag_ch12_q, diag_ch34_q} == $past(s_result))
    else $error("diag result not captured");
  a_diag_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !s_done || !clk_en |=> $stable(diag_ch34_q))
    else $error("diag report changed without result");
  a_line_upper_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == `ADFSR_ADDR_LINE_OUT
    |=> reg_rdata[7:4] == 4'h0)
    else $error("line report upper bits set");
  a_global_upper_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == `ADFSR_ADDR_GLOBAL_ONE
    |=> reg_rdata[7:5] == 3'h0)
    else $error("global reserved bits set");
  a_fault_track: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en |=> ch_fault_q == $past({s_oc, s_dc}))
    else $error("fault register not tracking");
  a_global_track: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en |=> global_q[4:0] == $past(s_global))
    else $error("global register not tracking");
  a_state_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == `ADFSR_ADDR_CH_STATE
    |=> reg_rdata == $past(state_sync_q))
    else $error("state readback wrong");
  a_write_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && !s_done |=> $stable(diag_ch12_q) && $stable(diag_ch34_q))
    else $error("write changed status");
  a_batuv_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == `ADFSR_ADDR_GLOBAL_ONE
    |=> reg_rdata[0] == $past(global_q[0]))
    else $error("battery uv readback wrong");
  a_fault_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == `ADFSR_ADDR_CH_FAULT
    |=> reg_rdata[3:0] == $past(ch_fault_q[3:0]))
    else $error("dc fault readback wrong");

  ////////////////////////////////////////////////////////////////////////
  // readback of the diag, line, overcurrent, clock and supply fields against their stored values, plus zero on unmapped reads and read data held on writes
  sequence s_read_at(logic [7:0] a);
    clk_en && reg_rd && reg_addr == a;
  endsequence

  sequence s_fault_trig;
    clk_en && !auto_diag_skip && fault_rise;
  endsequence

  a_diag12_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_read_at(`ADFSR_ADDR_DIAG_CH12) |=> reg_rdata == $past(diag_ch12_q))
    else $error("ch12 report readback wrong");

  a_diag34_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_read_at(`ADFSR_ADDR_DIAG_CH34) |=> reg_rdata == $past(diag_ch34_q))
    else $error("ch34 report readback wrong");

  a_line_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_read_at(`ADFSR_ADDR_LINE_OUT)
    |=> reg_rdata[3:0] == $past(line_out_q))
    else $error("line report readback wrong");

  a_oc_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_read_at(`ADFSR_ADDR_CH_FAULT)
    |=> reg_rdata[7:4] == $past(ch_fault_q[7:4]))
    else $error("overcurrent readback wrong");

  a_clkbad_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_read_at(`ADFSR_ADDR_GLOBAL_ONE)
    |=> reg_rdata[4] == $past(global_q[4]))
    else $error("clock fault readback wrong");

  a_supply_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_read_at(`ADFSR_ADDR_GLOBAL_ONE)
    |=> reg_rdata[3:1] == $past(global_q[3:1]))
    else $error("supply fault readback wrong");

  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_rd && !is_mapped(reg_addr) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_rdata_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && !reg_rd |=> $stable(reg_rdata))
    else $error("write disturbed read data");

  ////////////////////////////////////////////////////////////////////////
  // capture, trigger and freeze behaviour
  a_diag34_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && s_done |=> diag_ch34_q == $past(s_result[7:0]))
    else $error("ch34 result not captured");

  a_diag12_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !s_done || !clk_en |=> $stable(diag_ch12_q))
    else $error("ch12 report changed without result");

  a_line_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && s_done && line_level_diag_enable
    |=> line_out_q == $past(s_line))
    else $error("line result not captured");

  a_diag_on_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_fault_trig |=> diag_start)
    else $error("diag not started after fault");

  // a start with no cause would rerun diagnostics and upset playback
  a_no_stray_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !leave_hiz && !fault_rise |=> !diag_start)
    else $error("diag started without cause");

  a_freeze_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clk_en |=> $stable(ch_fault_q) && $stable(global_q) &&
    $stable(diag_start) && $stable(reg_rdata))
    else $error("state moved while frozen");

endmodule : adfsr_status_regs
`default_nettype wire

// ===== adfsr_diag_model.sv
// diagnostic engine stand-in answering each diag_start with a result
`timescale 1ns/1ps
`default_nettype none
module adfsr_diag_model (
  // clock, reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // request and answer
  input  wire logic        diag_start,
  input  wire logic [15:0] result_val,
  output logic             diag_done,
  output logic      [15:0] diag_result,
  output int               starts
);
  logic [7:0] cnt_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 8'h00;
      starts <= 0;
    end else if (diag_start) begin
      cnt_q  <= 8'h0C;
      starts <= starts + 1;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // done stands four cycles; result is scrambled outside that window
  assign diag_done   = (cnt_q != 8'h00) && (cnt_q <= 8'h04);
  assign diag_result = diag_done ? result_val : ~result_val;
endmodule : adfsr_diag_model
`default_nettype wire

// ===== adfsr_status_regs_tb.sv
// self-checking bench for the amplifier status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) check_count++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end
module adfsr_status_regs_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ch_state;
  logic reg_rd = 1'b0, reg_wr = 1'b0, reg_hit, diag_start, diag_done;
  logic auto_diag_skip = 1'b1, line_level_diag_enable = 1'b0;
  logic [15:0] diag_result, diag_val = 16'h9A3C;
  logic [3:0] line_level_detect_flag = 4'hF;
  logic [3:0] overcurrent_flag = 4'h0, dc_offset_fault_flag = 4'h0;
  logic clock_invalid, output_supply_overvoltage, battery_overvoltage;
  logic output_supply_undervoltage, battery_undervoltage;
  logic [7:0] rst_exp [6] = '{8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00};
  int errors = 0, check_count = 0, starts;
  initial ch_state = 8'h55;
  initial {clock_invalid, output_supply_overvoltage, battery_overvoltage,
    output_supply_undervoltage, battery_undervoltage} = 5'h00;
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  adfsr_status_regs dut (.*);
  adfsr_diag_model partner (.ref_clk(ref_clk), .rst_n(rst_n),
    .diag_start(diag_start), .result_val(diag_val),
    .diag_done(diag_done), .diag_result(diag_result), .starts(starts));
  ////////////////////////////////////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : tick
  task chk(input logic [7:0] a, input logic [7:0] exp, input logic hx);
    logic h;
    reg_addr = a;
    reg_rd   = 1'b1;
    #1 h = reg_hit;
    @(posedge ref_clk);
    #2 reg_rd = 1'b0;
    tick(1);
    `CHK(reg_rdata, exp)
    `CHK(h, hx)
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1'b1;
    @(posedge ref_clk);
    #2 reg_wr = 1'b0;
    tick(1);
  endtask : wr
  task fin(input string s);
    $display("test %s done", s);
  endtask : fin
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      chk(8'h0C + i[7:0], rst_exp[i], 1'b1);
    end
    chk(8'h12, 8'h00, 1'b0);
    fin("reset");
    wr(8'h0F, 8'hFF);
    wr(8'h10, 8'hFF);
    chk(8'h0F, 8'h55, 1'b1);
    chk(8'h10, 8'h00, 1'b1);
    fin("writes");
    overcurrent_flag     = 4'hA;
    dc_offset_fault_flag = 4'h5;
    ch_state             = 8'h1B;
    tick(4);
    chk(8'h10, 8'hA5, 1'b1);
    chk(8'h0F, 8'h1B, 1'b1);
    for (int i = 0; i < 5; i++) begin
      {clock_invalid, output_supply_overvoltage, battery_overvoltage,
        output_supply_undervoltage, battery_undervoltage} = 5'h01 << i;
      tick(4);
      chk(8'h11, 8'h01 << i, 1'b1);
    end
    `CHK(starts, 0)
    fin("faults");
    overcurrent_flag     = 4'h0;
    dc_offset_fault_flag = 4'h0;
    ch_state             = 8'h55;
    tick(4);
    auto_diag_skip = 1'b0;
    ch_state       = 8'h15;
    tick(30);
    `CHK(starts, 1)
    chk(8'h0C, 8'h9A, 1'b1);
    chk(8'h0D, 8'h3C, 1'b1);
    chk(8'h0E, 8'h00, 1'b1);
    fin("diag_hiz");
    diag_val               = 16'h5A0F;
    line_level_diag_enable = 1'b1;
    overcurrent_flag       = 4'h8;
    tick(30);
    `CHK(starts, 2)
    chk(8'h0C, 8'h5A, 1'b1);
    chk(8'h0D, 8'h0F, 1'b1);
    chk(8'h0E, 8'h0F, 1'b1);
    fin("diag_fault");
    wrap_up();
  end
endmodule : adfsr_status_regs_tb
`default_nettype wire
